// >>> verilog/sec_engine.sv
`timescale 1ns/10ps
`default_nettype none
module sec_engine
    import sec_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF,
    parameter int PROG_CYCLES = PROG_CYCLES_DEF
)
(
    // System clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // Serial link
    input wire logic chip_select_in,
    input wire logic serial_clock_in,
    input wire logic serial_data_in,
    output logic data_out_out,
    output logic data_oe_n_out,
    // Status
    output logic program_enable_out,
    output logic busy_out
);
    localparam int HDR_W = OP_W + ADDR_W;
    localparam logic [CNT_W-1:0] HDR_LAST = CNT_W'(HDR_W - 1);
    localparam logic [CNT_W-1:0] NEED_CMD = CNT_W'(HDR_W);
    localparam logic [CNT_W-1:0] NEED_DATA = CNT_W'(HDR_W + DATA_W);
    localparam logic [CNT_W-1:0] CNT_SAT = CNT_W'(HDR_W + DATA_W + 1);
    localparam logic [CNT_W-1:0] EXT_MIN = CNT_W'(EXT_MIN_BITS);
    localparam int IDX_W = $clog2(DATA_W);
    localparam logic [IDX_W-1:0] IDX_TOP = IDX_W'(DATA_W - 1);
    localparam int PCW = $clog2(PROG_CYCLES + 1);
    localparam logic [PCW-1:0] PROG_LAST = PCW'(PROG_CYCLES - 1);

    // Link side, frame phase: cleared while chip select is low
    sec_phase_e phase, next_phase;
    logic [ADDR_W-1:0] rd_addr, next_rd_addr;
    logic [IDX_W-1:0] rd_idx, next_rd_idx;
    logic link_do, next_link_do;
    // Link side, captured frame: held after select falls; busy_l1/busy_l2 still follow busy on every link clock
    logic [HDR_W-1:0] hdr, next_hdr;
    logic [DATA_W-1:0] wdata, next_wdata;
    logic [CNT_W-1:0] cnt, next_cnt;
    logic start_tgl, next_start_tgl;
    logic busy_l1, busy_l2, next_busy_l1, next_busy_l2;
    // System side
    logic cs_s1, cs_s2, cs_prev, tgl_s1, tgl_s2, tgl_ack;
    logic next_cs_s1, next_cs_s2, next_cs_prev;
    logic next_tgl_s1, next_tgl_s2, next_tgl_ack;
    logic busy, pe, armed, status_do, link_clr;
    logic next_busy, next_pe, next_armed, next_status_do, next_link_clr;
    logic [PCW-1:0] prog_cnt, next_prog_cnt;
    logic pend_all, next_pend_all;
    logic [ADDR_W-1:0] pend_addr, next_pend_addr;
    logic [DATA_W-1:0] pend_data, next_pend_data;
    logic wr_strobe, go, cs_fall, new_frame, take_start;
    logic drive_read, drive_status;
    logic [OP_W-1:0] op;
    logic [EXT_W-1:0] ext;
    logic [DATA_W-1:0] rd_word;
    logic [HDR_W-1:0] hdr_al;

    sec_array #(
        .ADDR_W(ADDR_W)
    ) u_array (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .wr_in(wr_strobe),
        .all_in(pend_all),
        .wr_addr_in(pend_addr),
        .wr_data_in(pend_data),
        .rd_addr_in(rd_addr),
        .rd_data_out(rd_word)
    );

    // Start bit refused while deselected or programming is seen busy
    assign take_start = chip_select_in && serial_data_in
        && !busy_l2;
    // Short lock/unlock frames leave their code in the low header bits
    assign hdr_al = (cnt < NEED_CMD) ? hdr << (NEED_CMD - cnt)
        : hdr;
    assign op = hdr_al[HDR_W-1 -: OP_W];
    assign ext = hdr_al[HDR_W-OP_W-1 -: EXT_W];

    always_comb
    begin
        next_phase = phase;
        next_rd_addr = rd_addr;
        next_rd_idx = rd_idx;
        next_link_do = link_do;
        case (phase)
            PH_IDLE:
            begin
                if (take_start)
                begin
                    next_phase = PH_CMD;
                end
            end
            PH_CMD:
            begin
                if (cnt == HDR_LAST)
                begin
                    if (next_hdr[HDR_W-1 -: OP_W] == OP_READ)
                    begin
                        next_phase = PH_READ;
                        next_rd_addr = next_hdr[ADDR_W-1:0];
                        next_rd_idx = IDX_TOP;
                        next_link_do = 1'b0;
                    end
                    else
                    begin
                        next_phase = PH_DATA;
                    end
                end
            end
            PH_READ:
            begin
                next_link_do = rd_word[rd_idx];
                if (rd_idx == '0)
                begin
                    next_rd_addr = rd_addr + 1'b1;
                    next_rd_idx = IDX_TOP;
                end
                else
                begin
                    next_rd_idx = rd_idx - 1'b1;
                end
            end
            default:
            begin
                next_phase = phase;
            end
        endcase
    end

    // Select low holds the frame logic idle, whatever the clock does
    always_ff @(posedge serial_clock_in or negedge chip_select_in)
    begin
        if (!chip_select_in)
        begin
            phase <= PH_IDLE;
            rd_addr <= '0;
            rd_idx <= '0;
            link_do <= 1'b0;
        end
        else
        begin
            phase <= next_phase;
            rd_addr <= next_rd_addr;
            rd_idx <= next_rd_idx;
            link_do <= next_link_do;
        end
    end

    always_comb
    begin
        next_hdr = hdr;
        next_wdata = wdata;
        next_cnt = cnt;
        next_start_tgl = start_tgl;
        next_busy_l1 = busy;
        next_busy_l2 = busy_l1;
        if (phase == PH_IDLE)
        begin
            if (take_start)
            begin
                next_hdr = '0;
                next_wdata = '0;
                next_cnt = '0;
                next_start_tgl = !start_tgl;
            end
        end
        else if (phase != PH_READ)
        begin
            if (phase == PH_CMD)
            begin
                next_hdr = {hdr[HDR_W-2:0], serial_data_in};
            end
            else
            begin
                next_wdata = {wdata[DATA_W-2:0], serial_data_in};
            end
            if (cnt != CNT_SAT)
            begin
                next_cnt = cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge serial_clock_in or posedge link_clr)
    begin
        if (link_clr)
        begin
            hdr <= '0;
            wdata <= '0;
            cnt <= '0;
            start_tgl <= 1'b0;
            busy_l1 <= 1'b0;
            busy_l2 <= 1'b0;
        end
        else
        begin
            hdr <= next_hdr;
            wdata <= next_wdata;
            cnt <= next_cnt;
            start_tgl <= next_start_tgl;
            busy_l1 <= next_busy_l1;
            busy_l2 <= next_busy_l2;
        end
    end

    // System side: frame commit, programming timer, status
    assign cs_fall = cs_prev && !cs_s2;
    assign new_frame = tgl_s2 != tgl_ack;

    always_comb
    begin
        next_cs_s1 = chip_select_in;
        next_cs_s2 = cs_s1;
        next_cs_prev = cs_s2;
        next_tgl_s1 = start_tgl;
        next_tgl_s2 = tgl_s1;
        next_tgl_ack = tgl_ack;
        next_link_clr = 1'b0;
        next_busy = busy;
        next_pe = pe;
        next_armed = armed;
        next_prog_cnt = prog_cnt;
        next_pend_all = pend_all;
        next_pend_addr = pend_addr;
        next_pend_data = pend_data;
        wr_strobe = 1'b0;
        go = 1'b0;
        if (busy)
        begin
            if (prog_cnt == PROG_LAST)
            begin
                next_busy = 1'b0;
                wr_strobe = 1'b1;
            end
            else
            begin
                next_prog_cnt = prog_cnt + 1'b1;
            end
        end
        if (cs_s2 && new_frame)
        begin
            next_armed = 1'b0;
        end
        if (cs_fall)
        begin
            next_tgl_ack = tgl_s2;
            if (!busy)
            begin
                next_armed = 1'b0;
                next_pend_addr = hdr[ADDR_W-1:0];
                next_pend_all = 1'b0;
                next_pend_data = ERASED_WORD;
                if (new_frame)
                begin
                    case (op)
                        OP_WRITE:
                        begin
                            go = cnt == NEED_DATA;
                            next_pend_data = wdata;
                        end
                        OP_ERASE:
                        begin
                            go = cnt == NEED_CMD;
                        end
                        OP_EXT:
                        begin
                            case (ext)
                                EXT_FILL_ALL:
                                begin
                                    go = cnt == NEED_DATA;
                                    next_pend_all = 1'b1;
                                    next_pend_data = wdata;
                                end
                                EXT_ERASE_ALL:
                                begin
                                    go = cnt == NEED_CMD;
                                    next_pend_all = 1'b1;
                                end
                                default:
                                begin
                                    if (cnt >= EXT_MIN && cnt <= NEED_CMD)
                                    begin
                                        next_pe = ext == EXT_WRITE_UNLOCK;
                                    end
                                end
                            endcase
                        end
                        default:
                        begin
                            go = 1'b0;
                        end
                    endcase
                    if (go && pe)
                    begin
                        next_busy = 1'b1;
                        next_armed = 1'b1;
                        next_prog_cnt = '0;
                    end
                end
            end
        end
        next_status_do = !next_busy;
    end

    always_ff @(posedge clock_in)
    begin
        if (!rst_n_in)
        begin
            cs_s1 <= 1'b0;
            cs_s2 <= 1'b0;
            cs_prev <= 1'b0;
            tgl_s1 <= 1'b0;
            tgl_s2 <= 1'b0;
            tgl_ack <= 1'b0;
            link_clr <= 1'b1;
            busy <= 1'b0;
            pe <= 1'b0;
            armed <= 1'b0;
            status_do <= 1'b1;
            prog_cnt <= '0;
            pend_all <= 1'b0;
            pend_addr <= '0;
            pend_data <= ERASED_WORD;
        end
        else
        begin
            cs_s1 <= next_cs_s1;
            cs_s2 <= next_cs_s2;
            cs_prev <= next_cs_prev;
            tgl_s1 <= next_tgl_s1;
            tgl_s2 <= next_tgl_s2;
            tgl_ack <= next_tgl_ack;
            link_clr <= next_link_clr;
            busy <= next_busy;
            pe <= next_pe;
            armed <= next_armed;
            status_do <= next_status_do;
            prog_cnt <= next_prog_cnt;
            pend_all <= next_pend_all;
            pend_addr <= next_pend_addr;
            pend_data <= next_pend_data;
        end
    end

    assign drive_read = phase == PH_READ;
    assign drive_status = armed && cs_s2 && chip_select_in
        && phase == PH_IDLE;
    assign data_out_out = drive_read ? link_do : (drive_status && status_do);
    assign data_oe_n_out = !(drive_read || drive_status);
    assign program_enable_out = pe;
    assign busy_out = busy;

    sequence s_a0_read;
        phase == PH_CMD && cnt == HDR_LAST
            && next_hdr[HDR_W-1 -: OP_W] == OP_READ;
    endsequence

    a_read_lead_zero: assert property (
        @(posedge serial_clock_in) disable iff (!chip_select_in || link_clr)
        s_a0_read |=> (!data_oe_n_out && !data_out_out) ##1 drive_read)
        else $error("read did not lead with a driven low bit");
    a_read_wrap: assert property (
        @(posedge serial_clock_in) disable iff (!chip_select_in || link_clr)
        (drive_read && rd_idx == '0 && rd_addr == {ADDR_W{1'b1}})
            |=> rd_addr == '0)
        else $error("sequential read did not wrap to zero");
    a_dummy_ignored: assert property (
        @(posedge serial_clock_in) disable iff (!chip_select_in || link_clr)
        (phase == PH_IDLE && !serial_data_in) |=> phase == PH_IDLE)
        else $error("low data bit taken as start");
    a_standby_hiz: assert property (
        @(posedge clock_in) disable iff (!rst_n_in)
        !cs_s2 |-> data_oe_n_out)
        else $error("output driven while deselected");
    a_lock_blocks: assert property (
        @(posedge clock_in) disable iff (!rst_n_in)
        (cs_fall && !busy && new_frame && !pe) |=> !busy)
        else $error("array operation started while locked");
    a_count_exact: assert property (
        @(posedge clock_in) disable iff (!rst_n_in)
        (cs_fall && !busy && new_frame && op == OP_WRITE
            && cnt != NEED_DATA) |=> !busy)
        else $error("write with wrong clock count not cancelled");
    a_unlock_sets: assert property (
        @(posedge clock_in) disable iff (!rst_n_in)
        (cs_fall && !busy && new_frame && op == OP_EXT
            && ext == EXT_WRITE_UNLOCK && cnt == NEED_CMD) |=> pe)
        else $error("unlock did not enable programming");
    a_reset_locks: assert property (
        @(posedge clock_in) disable iff (!rst_n_in)
        $rose(rst_n_in) |-> (!pe && !busy))
        else $error("reset left programming enabled or busy");
    a_busy_ignores: assert property (
        @(posedge clock_in) disable iff (!rst_n_in)
        (busy && cs_fall) |=> ($stable(pe) && $stable(pend_data)))
        else $error("frame accepted during programming");
    a_prog_done: assert property (
        @(posedge clock_in) disable iff (!rst_n_in)
        (busy && prog_cnt == PROG_LAST) |-> wr_strobe ##1 (!busy && status_do))
        else $error("programming did not end on time");
    a_busy_shows: assert property (
        @(posedge clock_in) disable iff (!rst_n_in)
        (busy && $past(busy) && drive_status)
            |-> (!data_out_out && !data_oe_n_out))
        else $error("busy not shown low on output");
endmodule : sec_engine
`default_nettype wire

// >>> verilog/sec_pkg.sv
`default_nettype none
package sec_pkg;
    // Word and frame geometry
    localparam int DATA_W = 16;
    localparam int ADDR_W_DEF = 6;
    localparam int OP_W = 2;
    localparam int EXT_W = 2;
    localparam int CNT_W = 6;
    localparam int EXT_MIN_BITS = 4;

    // Opcodes; the extended group uses the top two address bits
    localparam logic [OP_W-1:0] OP_EXT = 2'h0;
    localparam logic [OP_W-1:0] OP_WRITE = 2'h1;
    localparam logic [OP_W-1:0] OP_READ = 2'h2;
    localparam logic [OP_W-1:0] OP_ERASE = 2'h3;
    localparam logic [EXT_W-1:0] EXT_WRITE_LOCK = 2'h0;
    localparam logic [EXT_W-1:0] EXT_FILL_ALL = 2'h1;
    localparam logic [EXT_W-1:0] EXT_ERASE_ALL = 2'h2;
    localparam logic [EXT_W-1:0] EXT_WRITE_UNLOCK = 2'h3;

    localparam logic [DATA_W-1:0] ERASED_WORD = 16'hffff;

    // Self-timed programming
    localparam int CLOCK_MHZ = 25;
    localparam int PROGRAM_TIME_TYP_US = 4000;
    localparam int PROGRAM_TIME_MAX_US = 8000;
    localparam int PROG_CYCLES_DEF = PROGRAM_TIME_TYP_US * CLOCK_MHZ;

    // Link frame phase, Gray along idle, command, data
    typedef enum logic [1:0] {
        PH_IDLE = 2'h0,
        PH_CMD = 2'h1,
        PH_DATA = 2'h3,
        PH_READ = 2'h2
    } sec_phase_e;
endpackage : sec_pkg
`default_nettype wire

// >>> verilog/sec_array.sv
`timescale 1ns/10ps
`default_nettype none
module sec_array
    import sec_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF
)
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // Write port
    input wire logic wr_in,
    input wire logic all_in,
    input wire logic [ADDR_W-1:0] wr_addr_in,
    input wire logic [DATA_W-1:0] wr_data_in,
    // Read port
    input wire logic [ADDR_W-1:0] rd_addr_in,
    output logic [DATA_W-1:0] rd_data_out
);
    localparam int WORDS = 1 << ADDR_W;

    logic [DATA_W-1:0] mem [WORDS];

    generate
        for (genvar w = 0; w < WORDS; w++)
        begin : g_word
            logic [DATA_W-1:0] next_word;
            always_comb
            begin
                next_word = mem[w];
                if (wr_in && (all_in || wr_addr_in == ADDR_W'(w)))
                begin
                    next_word = wr_data_in;
                end
            end
            always_ff @(posedge clock_in)
            begin
                if (!rst_n_in)
                begin
                    mem[w] <= ERASED_WORD;
                end
                else
                begin
                    mem[w] <= next_word;
                end
            end
        end
    endgenerate

    assign rd_data_out = mem[rd_addr_in];
endmodule : sec_array
`default_nettype wire

// >>> verification/sec_host.sv
`timescale 1ns/10ps
`default_nettype none
module sec_host
(
    // Link towards the memory
    output logic chip_select_out,
    output logic serial_clock_out,
    output logic serial_data_out,
    // Memory answer
    input wire logic data_out_in,
    input wire logic data_oe_n_in
);
    logic [15:0] rx_q[$];
    logic first_oe_n;
    logic first_data;
    initial
    begin
        chip_select_out = 1'b0;
        serial_clock_out = 1'b0;
        serial_data_out = 1'b0;
    end
    // One 48 ns link clock; data moves only while the clock is low
    task automatic pulse(input logic v);
        serial_data_out = v;
        #24 serial_clock_out = 1'b1;
        #24 serial_clock_out = 1'b0;
    endtask : pulse
    task automatic frame(input int dum, input int n, input logic [39:0] b,
                         input int nw);
        logic [15:0] w;
        chip_select_out = 1'b1;
        #100;
        repeat (dum) pulse(1'b0);
        for (int i = n - 1; i >= 0; i--)
            pulse(b[i]);
        first_oe_n = data_oe_n_in;
        first_data = data_out_in;
        for (int k = 0; k < nw; k++)
        begin
            for (int j = 15; j >= 0; j--)
            begin
                pulse(1'b0);
                w[j] = data_out_in;
            end
            rx_q.push_back(w);
        end
        #48 chip_select_out = 1'b0;
        // Stray clocks with a high data line while deselected
        repeat (2) pulse(1'b1);
        #300;
    endtask : frame
    // Brief reselect to sample status, then deselect again
    task automatic peek(output logic v, output logic oe_n);
        serial_data_out = 1'b0;
        chip_select_out = 1'b1;
        #100;
        v = data_out_in;
        oe_n = data_oe_n_in;
        chip_select_out = 1'b0;
        #180;
    endtask : peek
    // Hold select high until ready, then start a frame on top of it
    task automatic poll(output logic sb, output logic sr, output logic rel);
        sb = 1'b0;
        sr = 1'b0;
        rel = 1'b0;
        chip_select_out = 1'b1;
        serial_data_out = 1'b0;
        for (int t = 0; t < 200 && sr !== 1'b1; t++)
        begin
            #40;
            if (data_oe_n_in === 1'b0 && data_out_in === 1'b0)
                sb = 1'b1;
            if (data_oe_n_in === 1'b0 && data_out_in === 1'b1)
                sr = 1'b1;
        end
        if (sr === 1'b1)
        begin
            pulse(1'b1);
            rel = data_oe_n_in;
        end
        #48 chip_select_out = 1'b0;
        serial_data_out = ~serial_data_out;
        #400;
    endtask : poll
endmodule : sec_host
`default_nettype wire

// >>> verification/serial_eeprom_command_engine_tb.sv
`timescale 1ns/10ps
`default_nettype none
module serial_eeprom_command_engine_tb
    import sec_pkg::*;
;
    localparam int PC = 20;
    localparam int CEIL = 60000;
    logic clock_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic cs;
    logic sck;
    logic sdi;
    logic dout;
    logic doe_n;
    logic program_enable_out;
    logic busy_out;
    logic [DATA_W-1:0] mem [64];
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;
    int run_len = 0;
    int last_len = 0;
    int n_runs = 0;
    always #20 clock_in = ~clock_in;
    sec_engine #(.ADDR_W(6), .PROG_CYCLES(PC)) dut_u (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .chip_select_in(cs),
        .serial_clock_in(sck),
        .serial_data_in(sdi),
        .data_out_out(dout),
        .data_oe_n_out(doe_n),
        .program_enable_out(program_enable_out),
        .busy_out(busy_out)
    );
    sec_host host_u (
        .chip_select_out(cs),
        .serial_clock_out(sck),
        .serial_data_out(sdi),
        .data_out_in(dout),
        .data_oe_n_in(doe_n)
    );
    task automatic close_out();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen,
                     exp);
        end
    endtask : chk
    // Busy run lengths, measured in system clocks
    always @(posedge clock_in)
    begin
        cycles <= cycles + 1;
        if (busy_out === 1'b1)
            run_len <= run_len + 1;
        else if (run_len != 0)
        begin
            last_len <= run_len;
            n_runs <= n_runs + 1;
            run_len <= 0;
        end
        if (cycles == CEIL)
        begin
            failures++;
            close_out();
        end
    end
    function automatic logic [39:0] f9(logic [1:0] op, logic [5:0] a);
        return {31'h0, 1'b1, op, a};
    endfunction : f9
    function automatic logic [39:0] f25(logic [1:0] op, logic [5:0] a,
                                        logic [15:0] d);
        return {15'h0, 1'b1, op, a, d};
    endfunction : f25
    task automatic issue(input logic [39:0] b, input int n, input int dum,
                         input logic go);
        logic sb;
        logic sr;
        logic rel;
        logic pv;
        logic poe;
        int runs0;
        runs0 = n_runs;
        host_u.frame(dum, n, b, 0);
        host_u.peek(pv, poe);
        host_u.poll(sb, sr, rel);
        chk(poe, !go);
        chk(sb, go);
        chk(sr, go);
        chk(n_runs - runs0, go);
        if (go)
        begin
            chk(pv, 1'b0);
            chk(rel, 1'b1);
            chk(last_len, PC);
        end
    endtask : issue
    task automatic rd(input logic [5:0] a, input int nw);
        logic [5:0] p;
        p = a;
        host_u.frame(0, 9, f9(OP_READ, a), nw);
        chk(host_u.first_oe_n, 1'b0);
        chk(host_u.first_data, 1'b0);
        repeat (nw)
        begin
            chk(host_u.rx_q.pop_front(), mem[p]);
            p = p + 1'b1;
        end
    endtask : rd
    initial
    begin
        logic [5:0] a;
        logic [15:0] d;
        void'($urandom(32'he7a3_29bb));
        foreach (mem[i]) mem[i] = ERASED_WORD;
        repeat (20) @(posedge clock_in);
        rst_n_in <= 1'b1;
        repeat (4) @(posedge clock_in);
        chk(program_enable_out, 1'b0);
        chk(busy_out, 1'b0);
        chk(doe_n, 1'b1);
        issue(f25(OP_WRITE, 6'h05, 16'h1234), 25, 0, 1'b0);
        rd(6'h05, 1);
        $display("test locked write done");
        issue(f9(OP_EXT, {EXT_WRITE_UNLOCK, 4'h0}) >> 4, 5, 0, 1'b0);
        chk(program_enable_out, 1'b1);
        for (int k = 0; k < 4; k++)
        begin
            a = (k == 0) ? 6'h00 : (k == 1) ? 6'h3e : (k == 2) ? 6'h3f :
                6'($urandom_range(1, 61));
            d = 16'($urandom());
            issue(f25(OP_WRITE, a, d), 25, 2 * k, 1'b1);
            mem[a] = d;
        end
        rd(6'h3e, 3);
        $display("test word writes and wrap done");
        d = 16'($urandom());
        issue(f25(OP_WRITE, 6'h3f, d) << 1, 26, 0, 1'b0);
        issue(f25(OP_WRITE, 6'h3f, d) >> 1, 24, 0, 1'b0);
        issue(f9(OP_ERASE, 6'h3f) << 1, 10, 0, 1'b0);
        issue(f9(OP_ERASE, 6'h00), 9, 0, 1'b1);
        mem[0] = ERASED_WORD;
        rd(6'h3f, 2);
        $display("test clock count and erase done");
        issue(f25(OP_EXT, {EXT_FILL_ALL, 4'h9}, d), 25, 0, 1'b1);
        foreach (mem[i]) mem[i] = d;
        rd(6'h00, 64);
        issue(f9(OP_EXT, {EXT_ERASE_ALL, 4'h5}), 9, 0, 1'b1);
        foreach (mem[i]) mem[i] = ERASED_WORD;
        rd(6'h21, 2);
        $display("test whole array done");
        issue(f9(OP_EXT, {EXT_WRITE_LOCK, 4'h0}), 9, 0, 1'b0);
        chk(program_enable_out, 1'b0);
        issue(f25(OP_WRITE, 6'h01, 16'h0000), 25, 0, 1'b0);
        rd(6'h01, 1);
        $display("test lock done");
        issue(f9(OP_EXT, {EXT_WRITE_UNLOCK, 4'h0}), 9, 0, 1'b0);
        host_u.frame(0, 25, f25(OP_WRITE, 6'h07, 16'h0f0f), 0);
        chk(busy_out, 1'b1);
        @(posedge clock_in);
        rst_n_in <= 1'b0;
        repeat (3) @(posedge clock_in);
        rst_n_in <= 1'b1;
        repeat (4) @(posedge clock_in);
        chk(program_enable_out, 1'b0);
        chk(busy_out, 1'b0);
        chk(last_len < PC, 1'b1);
        rd(6'h07, 1);
        $display("test reset during busy done");
        close_out();
    end
endmodule : serial_eeprom_command_engine_tb
`default_nettype wire
